// ---- hdl/awr_top.sv ----
/*
 * alarm and warning recorder of a motor driver: detects alarms, drives
 * the warning output, keeps the warning history and raises an interrupt.
 * assumes pins arrive asynchronously, link events and the load torque
 * come from logic on the same clock, and software uses the strobe port.
 */
`timescale 1ns/1ps
module awr_top
    import awr_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,   // cycles per timeout unit
    parameter int TORQUE_W = 9              // load torque width, percent
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // asynchronous driver pins
    input wire awr_pins_t pins,
    // same-clock events from the link and drive logic
    input wire logic link_frame_ok,
    input wire logic link_error,
    input wire logic test_mode_exit,
    input wire logic assign_change,
    input wire logic [TORQUE_W-1:0] load_torque,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // driver outputs
    output logic warning_output,
    output logic alarm_output,
    output logic motor_enable,
    output logic [7:0] alarm_code,
    output logic [3:0] alarm_blinks,
    output logic irq
);

    initial
    begin
        if (TICK_LEN < 1 || TORQUE_W != 9)
            $error("awr_top: unsupported parameter value");
    end

    // ==========================================================
    // pin synchronisers
    awr_pins_t pins_meta_reg;   // first stage, read only by the second
    awr_pins_t pins_sync_reg;   // usable pin levels
    awr_pins_t pins_prev_reg;   // last cycle, for edges

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins_meta_reg <= '0;
            pins_sync_reg <= '0;
            pins_prev_reg <= '0;
        end
        else
        begin
            pins_meta_reg <= pins;
            pins_sync_reg <= pins_meta_reg;
            pins_prev_reg <= pins_sync_reg;
        end
    end

    // ==========================================================
    // configuration registers
    logic [15:0] timeout_reg;           // timeout interval in ticks
    logic [7:0] err_limit_reg;          // consecutive error alarm count
    logic [8:0] torque_lim_reg;         // torque limit percent
    logic [8:0] overload_reg;           // overload warning level
    logic [IRQ_W-1:0] irq_mask_reg;     // event enables
    logic wr_hit;                       // decoded write helpers
    logic alarm_reset;                  // software alarm reset pulse
    logic hist_clear;                   // maintenance clear pulse

    assign wr_hit = reg_write;
    assign alarm_reset = wr_hit && reg_addr == REG_ALARM;
    assign hist_clear = wr_hit && reg_addr == REG_HIST_CTRL && reg_wdata[0];

    // software settings; writes to other offsets are dropped
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timeout_reg <= RST_TIMEOUT;
            err_limit_reg <= RST_ERR_LIMIT;
            torque_lim_reg <= RST_TORQUE_LIM;
            overload_reg <= RST_OVERLOAD;
            irq_mask_reg <= RST_IRQ_MASK;
        end
        else if (wr_hit)
        begin
            if (reg_addr == REG_TIMEOUT)
                timeout_reg <= reg_wdata[15:0];
            else if (reg_addr == REG_ERR_LIMIT)
                err_limit_reg <= reg_wdata[7:0];
            else if (reg_addr == REG_TORQUE_LIM)
                torque_lim_reg <= reg_wdata[8:0];
            else if (reg_addr == REG_OVERLOAD)
                overload_reg <= reg_wdata[8:0];
            else if (reg_addr == REG_IRQ_MASK)
                irq_mask_reg <= reg_wdata[IRQ_W-1:0];
        end
    end

    // ==========================================================
    // link supervision: timeout and consecutive errors
    logic [$clog2(TICK_LEN+1)-1:0] tick_cnt_reg;  // cycles inside one unit
    logic [15:0] idle_cnt_reg;                      // units since last frame
    logic [7:0] err_cnt_reg;                        // consecutive errors
    logic timeout_hit;
    logic err_limit_hit;

    // units count only while the interval is armed; a good frame restarts it
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt_reg <= '0;
            idle_cnt_reg <= '0;
        end
        else if (link_frame_ok || timeout_reg == 16'h0000)
        begin
            tick_cnt_reg <= '0;
            idle_cnt_reg <= '0;
        end
        else if (tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_LEN - 1))
        begin
            tick_cnt_reg <= '0;
            if (idle_cnt_reg != timeout_reg)
                idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    assign timeout_hit = timeout_reg != 16'h0000 && idle_cnt_reg == timeout_reg;

    // errors in a row; saturates so the alarm stays clean
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            err_cnt_reg <= '0;
        else if (link_frame_ok)
            err_cnt_reg <= '0;
        else if (link_error && err_cnt_reg != 8'hFF)
            err_cnt_reg <= err_cnt_reg + 8'h01;
    end

    assign err_limit_hit = err_limit_reg != 8'h00 && err_cnt_reg >= err_limit_reg;

    // ==========================================================
    // alarm detection
    logic main_off_hit;     // main power alarm cause
    logic drive_open_hit;   // drive output alarm cause
    awr_alarm_t alarm_new;  // highest priority cause this cycle
    awr_alarm_t alarm_reg;  // latched alarm

    assign main_off_hit =
        (pins_sync_reg.run_cmd && pins_prev_reg.main_power_ok
            && !pins_sync_reg.main_power_ok)
        || (pins_sync_reg.run_cmd && !pins_prev_reg.run_cmd
            && !pins_sync_reg.main_power_ok && pins_sync_reg.control_power_ok);
    // open wiring only counts with the torque limit at 200 percent or more
    assign drive_open_hit = pins_sync_reg.drive_open
        && torque_lim_reg >= TORQUE_MIN_OPEN;

    // fixed priority when causes coincide; only one code can be shown
    always_comb
    begin
        alarm_new = '0;
        if (main_off_hit)
            alarm_new = '{1'b1, CODE_MAIN_OFF, BLINK_MAIN_OFF};
        else if (drive_open_hit)
            alarm_new = '{1'b1, CODE_DRIVE_OPEN, BLINK_DRIVE_OPEN};
        else if (pins_sync_reg.converter_alarm)
            alarm_new = '{1'b1, CODE_CONVERTER, BLINK_NONE};
        else if (timeout_hit)
            alarm_new = '{1'b1, CODE_TIMEOUT, BLINK_TIMEOUT};
        else if (err_limit_hit)
            alarm_new = '{1'b1, CODE_LINK_ERR, BLINK_NONE};
    end

    // first alarm holds until reset; a live cause re-raises at once
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            alarm_reg <= '0;
        else if (!alarm_reg.valid || alarm_reset)
            alarm_reg <= alarm_new;
    end

    // ==========================================================
    // warning causes, each a live level
    logic overload_warn;     // load above level
    logic op_err_reg;        // operation error held while inputs stay on
    logic serial_warn_reg;   // link error seen, until a good frame
    logic any_run_in;
    logic [2:0] warn_now;
    logic [2:0] warn_prev_reg;

    assign overload_warn = load_torque > overload_reg;
    assign any_run_in = pins_sync_reg.forward_run_input || pins_sync_reg.reverse_run_input;

    // operation error clears itself once the offending inputs drop
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            op_err_reg <= 1'b0;
        else if ((test_mode_exit && any_run_in)
                 || (assign_change && pins_sync_reg.assigned_terminal_on))
            op_err_reg <= 1'b1;
        else if (!any_run_in && !pins_sync_reg.assigned_terminal_on)
            op_err_reg <= 1'b0;
    end

    // serial warning: set wins over the clearing frame
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            serial_warn_reg <= 1'b0;
        else if (link_error)
            serial_warn_reg <= 1'b1;
        else if (link_frame_ok)
            serial_warn_reg <= 1'b0;
    end

    assign warn_now = {serial_warn_reg, op_err_reg, overload_warn};

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            warn_prev_reg <= '0;
        else
            warn_prev_reg <= warn_now;
    end

    // ==========================================================
    // history: one push per cycle with a new warning, only the lowest new bit recorded if several
    logic [2:0] warn_rise;
    logic hist_push;
    logic [7:0] hist_code;
    logic [7:0] hist_rd_code;
    logic [HIST_CNT_W-1:0] hist_count;
    logic [HIST_CNT_W-1:0] hist_index;

    assign warn_rise = warn_now & ~warn_prev_reg;
    assign hist_push = |warn_rise;
    assign hist_code = warn_rise[0] ? CODE_OVERLOAD
                     : warn_rise[1] ? CODE_OP_ERROR : CODE_SERIAL;
    assign hist_index = reg_addr[HIST_CNT_W+1:2];

    awr_history #(
        .DEPTH(HIST_DEPTH),
        .CODE_W(8)
    ) u_history (
        .clock(clock),
        .reset_n(reset_n),
        .push(hist_push),
        .push_code(hist_code),
        .clear(hist_clear),
        .rd_index(hist_index),
        .rd_code(hist_rd_code),
        .count(hist_count)
    );

    // ==========================================================
    // interrupt status: sticky, write one to clear, set wins
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_clear;

    always_comb
    begin
        irq_event = '0;
        irq_event[IB_TIMEOUT] = timeout_hit;
        irq_event[IB_CONVERTER] = pins_sync_reg.converter_alarm;
        irq_event[IB_MAIN_OFF] = main_off_hit;
        irq_event[IB_DRIVE_OPEN] = drive_open_hit;
        irq_event[IB_LINK_ERR] = err_limit_hit;
        irq_event[IB_OVERLOAD] = warn_rise[0];
        irq_event[IB_OP_ERROR] = warn_rise[1];
        irq_event[IB_SERIAL] = warn_rise[2];
    end

    assign irq_clear = (wr_hit && reg_addr == REG_IRQ_STATUS) ? reg_wdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            irq_status_reg <= '0;
        else
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
    end

    // ==========================================================
    // driver outputs, all registered
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            warning_output <= 1'b0;
            alarm_output <= 1'b0;
            motor_enable <= 1'b0;
            alarm_code <= '0;
            alarm_blinks <= '0;
            irq <= 1'b0;
        end
        else
        begin
            warning_output <= |warn_now;
            alarm_output <= alarm_reg.valid;
            // warnings never stop the motor, only alarms do
            motor_enable <= !alarm_reg.valid;
            alarm_code <= alarm_reg.code;
            alarm_blinks <= alarm_reg.blinks;
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ==========================================================
    // read data, valid the cycle after the strobe, zero elsewhere
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        if (reg_addr == REG_TIMEOUT)
            rd_mux = {16'h0000, timeout_reg};
        else if (reg_addr == REG_ERR_LIMIT)
            rd_mux = {24'h000000, err_limit_reg};
        else if (reg_addr == REG_TORQUE_LIM)
            rd_mux = {23'h000000, torque_lim_reg};
        else if (reg_addr == REG_OVERLOAD)
            rd_mux = {23'h000000, overload_reg};
        else if (reg_addr == REG_ALARM)
            rd_mux = {15'h0000, alarm_reg.valid, 4'h0, alarm_reg.blinks, alarm_reg.code};
        else if (reg_addr == REG_WARN)
            rd_mux = {28'h0000000, warning_output, warn_now};
        else if (reg_addr == REG_IRQ_STATUS)
            rd_mux = {24'h000000, irq_status_reg};
        else if (reg_addr == REG_IRQ_MASK)
            rd_mux = {24'h000000, irq_mask_reg};
        else if (reg_addr == REG_HIST_CTRL)
            rd_mux = {28'h0000000, hist_count};
        else if (reg_addr >= REG_HIST_BASE
                 && reg_addr < REG_HIST_BASE + 8'(4 * HIST_DEPTH)
                 && reg_addr[1:0] == 2'h0)
            rd_mux = {24'h000000, hist_rd_code};
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (reg_read)
            reg_rdata <= rd_mux;
        else
            reg_rdata <= '0;
    end

endmodule : awr_top

// ---- hdl/awr_pkg.sv ----
/*
 * shared constants and carrier types of the alarm and warning recorder:
 * alarm and warning codes, blink counts, register offsets, reset values,
 * interrupt bit positions and timing counts.
 * assumes a single 50 MHz clock domain and a plain strobe register port.
 */
package awr_pkg;

    // ==========================================================
    // timing
    localparam int CLOCK_HZ = 50_000_000;           // system clock rate
    localparam int TICK_US = 1000;                  // timeout unit, microseconds
    localparam int TICK_CYCLES = (CLOCK_HZ / 1_000_000) * TICK_US;

    // ==========================================================
    // alarm and warning codes with indicator blink counts
    localparam logic [7:0] CODE_TIMEOUT = 8'h85;    // link timeout alarm
    localparam logic [3:0] BLINK_TIMEOUT = 4'hC;    // 12 blinks
    localparam logic [7:0] CODE_CONVERTER = 8'h8E;  // network converter alarm
    localparam logic [7:0] CODE_LINK_ERR = 8'h84;   // consecutive link errors
    localparam logic [3:0] BLINK_NONE = 4'h0;       // no blink figure given
    localparam logic [7:0] CODE_MAIN_OFF = 8'h23;   // main power off alarm
    localparam logic [3:0] BLINK_MAIN_OFF = 4'hD;   // 13 blinks
    localparam logic [7:0] CODE_DRIVE_OPEN = 8'h2D; // drive output fault
    localparam logic [3:0] BLINK_DRIVE_OPEN = 4'hE; // 14 blinks
    localparam logic [7:0] CODE_OVERLOAD = 8'h30;   // overload warning
    localparam logic [7:0] CODE_OP_ERROR = 8'h6C;   // operation error warning
    localparam logic [7:0] CODE_SERIAL = 8'h84;     // serial error warning
    localparam logic [8:0] TORQUE_MIN_OPEN = 9'h0C8; // 200 percent

    // ==========================================================
    // history
    localparam int HIST_DEPTH = 10;                 // entries kept
    localparam int HIST_CNT_W = 4;                  // width of entry count

    // ==========================================================
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_TIMEOUT = 8'h00;     // timeout interval, ms
    localparam logic [7:0] REG_ERR_LIMIT = 8'h04;   // link error alarm count
    localparam logic [7:0] REG_TORQUE_LIM = 8'h08;  // torque limit, percent
    localparam logic [7:0] REG_OVERLOAD = 8'h0C;    // overload level, percent
    localparam logic [7:0] REG_ALARM = 8'h10;       // active alarm, write resets
    localparam logic [7:0] REG_WARN = 8'h14;        // warning causes
    localparam logic [7:0] REG_IRQ_STATUS = 8'h18;  // sticky events, w1c
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;    // event enables
    localparam logic [7:0] REG_HIST_CTRL = 8'h20;   // count, write bit0 clears
    localparam logic [7:0] REG_HIST_BASE = 8'h40;   // entry 0 is newest

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_TIMEOUT = 16'h0000; // zero disables timeout
    localparam logic [7:0] RST_ERR_LIMIT = 8'h03;
    localparam logic [8:0] RST_TORQUE_LIM = 9'h0C8;
    localparam logic [8:0] RST_OVERLOAD = 9'h064;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // ==========================================================
    // interrupt status bits
    localparam int IRQ_W = 8;
    localparam int IB_TIMEOUT = 0;
    localparam int IB_CONVERTER = 1;
    localparam int IB_MAIN_OFF = 2;
    localparam int IB_DRIVE_OPEN = 3;
    localparam int IB_LINK_ERR = 4;
    localparam int IB_OVERLOAD = 5;
    localparam int IB_OP_ERROR = 6;
    localparam int IB_SERIAL = 7;

    // field positions in the alarm and warning words
    localparam int ALM_VALID_BIT = 16;
    localparam int WARN_OUT_BIT = 3;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic main_power_ok;        // main supply present
        logic control_power_ok;     // control supply present
        logic run_cmd;              // operation command
        logic drive_open;           // drive wiring open detected
        logic converter_alarm;      // network converter reports alarm
        logic forward_run_input;    // forward run terminal
        logic reverse_run_input;    // reverse run terminal
        logic assigned_terminal_on; // terminal being reassigned is on
    } awr_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [3:0] blinks;
    } awr_alarm_t;

endpackage : awr_pkg

// ---- hdl/awr_history.sv ----
/*
 * warning history: a shift store of the newest entries, newest at index 0.
 * assumes push and clear are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
module awr_history
    import awr_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH,
    parameter int CODE_W = 8
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // control
    input wire logic push,
    input wire logic [CODE_W-1:0] push_code,
    input wire logic clear,
    // read side
    input wire logic [HIST_CNT_W-1:0] rd_index,
    output logic [CODE_W-1:0] rd_code,
    output logic [HIST_CNT_W-1:0] count
);

    initial
    begin
        if (DEPTH < 1 || DEPTH >= (1 << HIST_CNT_W))
            $error("awr_history: DEPTH out of range");
    end

    // ==========================================================
    // storage
    logic [CODE_W-1:0] entry_reg [DEPTH];   // entry 0 newest
    logic [HIST_CNT_W-1:0] count_reg;       // filled entries

    // shift in at the head; the oldest falls off the tail when full
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_entry
            always_ff @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                    entry_reg[gi] <= '0;
                else if (clear)
                    entry_reg[gi] <= '0;
                else if (push)
                begin
                    if (gi == 0)
                        entry_reg[gi] <= push_code;
                    else
                        entry_reg[gi] <= entry_reg[gi-1];
                end
            end
        end
    endgenerate

    // count saturates at depth
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            count_reg <= '0;
        else if (clear)
            count_reg <= '0;
        else if (push && count_reg != HIST_CNT_W'(DEPTH))
            count_reg <= count_reg + 1'b1;
    end

    // empty slots read as zero
    always_comb
    begin
        rd_code = '0;
        if (rd_index < count_reg)
            rd_code = entry_reg[rd_index];
    end

    assign count = count_reg;

endmodule : awr_history

// ---- tb/awr_top_sva.sv ----
/*
 * checker of the recorder's outputs, bound to the top module.
 * assumes only the top module's ports are visible.
 */
`timescale 1ns/1ps
module awr_checker
    import awr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // watched ports
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic warning_output,
    input wire logic alarm_output,
    input wire logic motor_enable,
    input wire logic [7:0] alarm_code,
    input wire logic [3:0] alarm_blinks
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // read data stands only in the cycle after a read strobe
    property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    // a warning alone never stops the motor
    property p_warn_runs; warning_output && !alarm_output |-> motor_enable; endproperty
    a_warn_runs: assert property (p_warn_runs) else $error("warning stopped motor");
    // a latched alarm always stops the motor
    property p_alarm_stops; alarm_output |-> !motor_enable; endproperty
    a_alarm_stops: assert property (p_alarm_stops) else $error("alarm kept motor on");
    // blink count follows the code
    property p_bl_to; alarm_code == CODE_TIMEOUT |-> alarm_blinks == 4'hC; endproperty
    a_bl_to: assert property (p_bl_to) else $error("timeout blinks wrong");
    property p_bl_cv; alarm_code == CODE_CONVERTER |-> alarm_blinks == 4'h0; endproperty
    a_bl_cv: assert property (p_bl_cv) else $error("converter blinks wrong");
    property p_bl_mo; alarm_code == CODE_MAIN_OFF |-> alarm_blinks == 4'hD; endproperty
    a_bl_mo: assert property (p_bl_mo) else $error("main off blinks wrong");
    property p_bl_do; alarm_code == CODE_DRIVE_OPEN |-> alarm_blinks == 4'hE; endproperty
    a_bl_do: assert property (p_bl_do) else $error("drive open blinks wrong");
    // a rising alarm carries one of the listed codes
    property p_code; $rose(alarm_output) |-> alarm_code inside {8'h85, 8'h8E, 8'h23, 8'h2D, 8'h84};
    endproperty
    a_code: assert property (p_code) else $error("alarm code unknown");
endmodule : awr_checker
bind awr_top awr_checker i_awr_checker (.clock(clock), .reset_n(reset_n), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .warning_output(warning_output), .alarm_output(alarm_output),
    .motor_enable(motor_enable), .alarm_code(alarm_code), .alarm_blinks(alarm_blinks));

// ---- tb/awr_master_model.sv ----
/*
 * link master model: turns bench requests into one-cycle frame events.
 * assumes frame decoding itself lies outside the recorder.
 */
`timescale 1ns/1ps
module awr_master_model
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // requests and events
    input wire logic send_ok,
    input wire logic send_err,
    output logic link_frame_ok,
    output logic link_error
);
    // a bad frame is never also reported good
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_frame_ok <= 1'b0;
            link_error <= 1'b0;
        end
        else
        begin
            link_frame_ok <= send_ok;
            link_error <= send_err & ~send_ok;
        end
    end
endmodule : awr_master_model

// ---- tb/tb_awr_top.sv ----
/*
 * testbench of the recorder: register tasks and directed tests.
 * assumes a short timeout unit of 10 cycles.
 */
`timescale 1ns/1ps
module tb_awr_top;
    import awr_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic send_ok = 1'b0, send_err = 1'b0, link_frame_ok, link_error;
    logic test_mode_exit = 1'b0, assign_change = 1'b0;
    logic [8:0] load_torque = 9'h000;
    logic [7:0] reg_addr = 8'h00, alarm_code;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic warning_output, alarm_output, motor_enable, irq;
    logic [3:0] alarm_blinks;
    awr_pins_t pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    int err_total = 0, compares = 0, cyc = 0;
    always #10 clock = ~clock;
    awr_top #(.TICK_LEN(10), .TORQUE_W(9)) i_awr_top (.clock(clock), .reset_n(reset_n),
        .pins(pins), .link_frame_ok(link_frame_ok), .link_error(link_error),
        .test_mode_exit(test_mode_exit), .assign_change(assign_change),
        .load_torque(load_torque), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .warning_output(warning_output), .alarm_output(alarm_output),
        .motor_enable(motor_enable), .alarm_code(alarm_code), .alarm_blinks(alarm_blinks),
        .irq(irq));
    awr_master_model i_awr_master_model (.clock(clock), .reset_n(reset_n), .send_ok(send_ok),
        .send_err(send_err), .link_frame_ok(link_frame_ok), .link_error(link_error));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clock) reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock) {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clock) reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : waitc
    task automatic tally_and_finish;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // hang guard: the tests take well under 2000 cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // main sequence
    initial
    begin
        waitc(2);
        reset_n <= 1'b1;
        rd(REG_HIST_CTRL, 32'h0);
        rd(8'h3C, 32'h0);
        rd(REG_IRQ_MASK, 32'h0);
        @(posedge clock) load_torque <= 9'h065;
        waitc(3);
        chk({warning_output, motor_enable}, 2'b11);
        rd(REG_HIST_BASE, 32'h30);
        wr(REG_IRQ_MASK, 32'h20);
        waitc(2);
        chk(irq, 1'b1);
        @(posedge clock) load_torque <= 9'h064;
        waitc(3);
        chk(warning_output, 1'b0);
        wr(REG_IRQ_STATUS, 32'h20);
        waitc(2);
        chk(irq, 1'b0);
        $display("test overload done");
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clock) load_torque <= 9'h0FF;
            waitc(2);
            @(posedge clock) load_torque <= 9'h000;
            waitc(2);
        end
        @(posedge clock) send_err <= 1'b1;
        @(posedge clock) send_err <= 1'b0;
        waitc(3);
        chk(warning_output, 1'b1);
        @(posedge clock) send_ok <= 1'b1;
        @(posedge clock) send_ok <= 1'b0;
        rd(REG_HIST_CTRL, 32'hA);
        rd(REG_HIST_BASE, 32'h84);
        rd(REG_HIST_BASE + 8'h24, 32'h30);
        wr(REG_HIST_CTRL, 32'h1);
        rd(REG_HIST_CTRL, 32'h0);
        rd(REG_HIST_BASE, 32'h0);
        @(posedge clock) pins.forward_run_input <= 1'b1;
        waitc(4);
        @(posedge clock) test_mode_exit <= 1'b1;
        @(posedge clock) test_mode_exit <= 1'b0;
        waitc(2);
        chk(warning_output, 1'b1);
        rd(REG_HIST_BASE, 32'h6C);
        $display("test history done");
        @(posedge clock) pins.main_power_ok <= 1'b0;
        waitc(5);
        @(posedge clock) pins.run_cmd <= 1'b1;
        waitc(8);
        chk({alarm_output, motor_enable, alarm_code, alarm_blinks}, 14'h223D);
        @(posedge clock) {pins.run_cmd, pins.main_power_ok} <= 2'b01;
        waitc(6);
        wr(REG_ALARM, 32'h0);
        waitc(3);
        chk(alarm_output, 1'b0);
        wr(REG_TORQUE_LIM, 32'hC7);
        @(posedge clock) pins.drive_open <= 1'b1;
        waitc(8);
        chk(alarm_output, 1'b0);
        wr(REG_TORQUE_LIM, 32'hC8);
        waitc(4);
        chk({alarm_output, alarm_code, alarm_blinks}, 13'h12DE);
        @(posedge clock) pins.drive_open <= 1'b0;
        waitc(6);
        wr(REG_ALARM, 32'h0);
        wr(REG_TIMEOUT, 32'h1);
        waitc(16);
        chk({alarm_output, alarm_code}, 9'h185);
        @(posedge clock) pins.converter_alarm <= 1'b1;
        waitc(4);
        wr(REG_ALARM, 32'h0);
        waitc(2);
        chk({alarm_code, alarm_blinks}, 12'h8E0);
        $display("test alarms done");
        tally_and_finish();
    end
endmodule : tb_awr_top
